// File: shared/nrcr_cfg.svh
// Constants for the cached NAND read host: opcodes, register map,
// field positions, reset values and pin timing counts.
// Assumes a single 50 MHz clock; included by its bare name.
`ifndef NRCR_CFG_SVH
`define NRCR_CFG_SVH

// Clock rate and rounding of a least time up to whole cycles
`define NRCR_CLK_MHZ 50
`define NRCR_CYC(ns) (((ns) * `NRCR_CLK_MHZ + 999) / 1000)

// Pin timing, least times in ns
`define NRCR_T_WP_NS 40
`define NRCR_T_WH_NS 40
`define NRCR_T_RP_NS 120
`define NRCR_T_REH_NS 40
`define NRCR_T_WB_NS 200
`define NRCR_WP_CYC 8'(`NRCR_CYC(`NRCR_T_WP_NS))
`define NRCR_WH_CYC 8'(`NRCR_CYC(`NRCR_T_WH_NS))
`define NRCR_RP_CYC 8'(`NRCR_CYC(`NRCR_T_RP_NS))
`define NRCR_REH_CYC 8'(`NRCR_CYC(`NRCR_T_REH_NS))
`define NRCR_WB_CYC 8'(`NRCR_CYC(`NRCR_T_WB_NS))

// Device opcodes
`define NRCR_OPC_READ 8'h00
`define NRCR_OPC_READ_GO 8'h30
`define NRCR_OPC_CACHE_GO 8'h31
`define NRCR_OPC_CACHE_LAST 8'h3F
`define NRCR_OPC_COL 8'h05
`define NRCR_OPC_COL_GO 8'hE0
`define NRCR_OPC_STATUS 8'h70
`define NRCR_OPC_RESET 8'hFF

// Register byte offsets
`define NRCR_REG_CMD 8'h00
`define NRCR_REG_COL 8'h04
`define NRCR_REG_ROW 8'h08
`define NRCR_REG_DATA 8'h0C
`define NRCR_REG_STATE 8'h10
`define NRCR_REG_IRQ_STAT 8'h14
`define NRCR_REG_IRQ_MASK 8'h18

// Interrupt bit positions
`define NRCR_IRQ_DONE 0
`define NRCR_IRQ_REFUSED 1
`define NRCR_IRQ_READY 2

// Reset values
`define NRCR_COL_RST 16'h0000
`define NRCR_ROW_RST 24'h000000
`define NRCR_MASK_RST 3'h0

`endif

// File: shared/nrcr_pkg.sv
// Types of the cached NAND read host: software ops, sequencer
// stages and the decoded shape of one device sequence.
package nrcr_pkg;

  // Op codes written to the command register, values 0 to 8
  typedef enum logic [3:0] {
    NRCR_OP_PAGE_READ,
    NRCR_OP_COL_CHANGE,
    NRCR_OP_CACHE_SEQ,
    NRCR_OP_CACHE_RAND,
    NRCR_OP_CACHE_LAST,
    NRCR_OP_READ_BYTE,
    NRCR_OP_STATUS,
    NRCR_OP_READ_MODE,
    NRCR_OP_RESET
  } nrcr_op_type;

  // Stage order matters: the sequencer walks it upward
  typedef enum logic [2:0] {
    S_IDLE, S_CMD1, S_ADDR, S_CMD2, S_WB, S_RB, S_READ, S_DONE
  } nrcr_st_type;

  typedef struct packed {
    logic c1_en;
    logic [7:0] c1;
    logic [2:0] naddr;
    logic c2_en;
    logic [7:0] c2;
    logic busy;
    logic rd;
  } nrcr_seq_type;

endpackage

// File: hw/nrcr_sync.sv
// Three-flop input synchroniser with agreement filter.
// Assumes the input is asynchronous to clk; output moves only
// when the second and third stages agree.
`timescale 1ns/1ps
module nrcr_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_q, s2_q, s3_q;

  // Stage one is read only by stage two
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
      q <= INIT;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        q <= s3_q;
      end
    end
  end
endmodule

// File: hw/nrcr_host.sv
// Host sequencer for random column and cached page reads on a NAND
// die, driven by software through a small register port.
// Assumes one 50 MHz clock; the die pins are asynchronous inputs.
//
// What this block does
// RL1: Column change is 05h, two column bytes, then E0h.
// RL2: Column change is refused until a plain page read has loaded a page.
// RL3: Column changes may repeat; they stay within the loaded page.
// RL4: Each read strobe pulse fetches one byte; column pointer advances.
// RL5: Cache mode starts after a page read; ready shows status 11.
// RL6: Opcode 31h fetches the next page of the same block.
// RL7: Random cached read is 00h, five address bytes, then 31h.
// RL8: First cached opcode after a page read leaves status 10.
// RL9: Further cached opcodes copy data to cache, fetch on, status 10.
// RL10: Opcode 3Fh copies data to cache, ends fetching, status 11.
// RL11: Status 00 busy, 10 cache readable and fetching, 11 all idle.
// RL12: After each cached busy phase output restarts at column 0.
// RL13: While the die is busy only status or reset are issued.
// RL14: While fetching, only status, read, cached, column, reset allowed.
// RL15: No 31h once the block's last page is in the data register.
// RL16: Random cached read keeps plane bit; else end with 3Fh first.
// RL17: After reading cache bytes continue with a cached opcode or 3Fh.
// RL18: Plain page read is 00h, five address bytes, 30h, then busy.
// RL19: Die busy times are configurable counts inside the die.
//
// The address map and the strobed register port were decided locally.
`timescale 1ns/1ps
`include "nrcr_cfg.svh"
module nrcr_host import nrcr_pkg::*; #(
  parameter int PAGES_PER_BLOCK = 128,
  parameter int PLANE_BIT = 7
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq,
  output logic nand_ce_n,
  output logic nand_cle,
  output logic nand_ale,
  output logic nand_we_n,
  output logic nand_re_n,
  output logic [7:0] nand_dq_out,
  output logic nand_dq_oe,
  input wire logic [7:0] nand_dq_in,
  input wire logic nand_rb_n
);
  localparam int PB = $clog2(PAGES_PER_BLOCK);

  logic rst_meta_q, rst_n_q;
  logic rb_s, rb_prev_q;
  logic [7:0] dq_s;
  nrcr_st_type st_q;
  nrcr_op_type op_q, cmd_op;
  nrcr_seq_type seq_q;
  logic ph_q;
  logic [7:0] tcnt_q, lo_cyc, hi_cyc;
  logic [2:0] acnt_q;
  logic [15:0] col_q, colp_q;
  logic [23:0] row_q;
  logic [7:0] data_q;
  logic [2:0] mask_q, stat_q, ev_set, ev_clr;
  logic loaded_q, cache_q, fetch_q;
  logic [1:0] exp_q;
  logic plane_q;
  logic [PB-1:0] page_q;
  logic cmd_wr, cmd_ok, start, refuse, wr_stage, last_page;
  logic [7:0] abyte;

  // Walk to the next stage this sequence needs
  function automatic nrcr_st_type after(nrcr_st_type st,
                                        nrcr_seq_type s);
    nrcr_st_type n;
    n = S_DONE;
    if (st == S_WB) begin
      n = S_RB;
    end else if (st < S_CMD1 && s.c1_en) begin
      n = S_CMD1;
    end else if (st < S_ADDR && s.naddr != 3'h0) begin
      n = S_ADDR;
    end else if (st < S_CMD2 && s.c2_en) begin
      n = S_CMD2;
    end else if (st < S_WB && s.busy) begin
      n = S_WB;
    end else if (st < S_READ && s.rd) begin
      n = S_READ;
    end
    return n;
  endfunction

  // Device sequence for each software op
  function automatic nrcr_seq_type decode(nrcr_op_type op);
    nrcr_seq_type s;
    s = '0;
    unique case (op)
      NRCR_OP_PAGE_READ: begin // [RL18]
        s.c1_en = 1'b1;
        s.c1 = `NRCR_OPC_READ;
        s.naddr = 3'h5;
        s.c2_en = 1'b1;
        s.c2 = `NRCR_OPC_READ_GO;
        s.busy = 1'b1;
      end
      NRCR_OP_COL_CHANGE: begin // [RL1]
        s.c1_en = 1'b1;
        s.c1 = `NRCR_OPC_COL;
        s.naddr = 3'h2;
        s.c2_en = 1'b1;
        s.c2 = `NRCR_OPC_COL_GO;
      end
      NRCR_OP_CACHE_SEQ: begin // [RL6]
        s.c1_en = 1'b1;
        s.c1 = `NRCR_OPC_CACHE_GO;
        s.busy = 1'b1;
      end
      NRCR_OP_CACHE_RAND: begin // [RL7]
        s.c1_en = 1'b1;
        s.c1 = `NRCR_OPC_READ;
        s.naddr = 3'h5;
        s.c2_en = 1'b1;
        s.c2 = `NRCR_OPC_CACHE_GO;
        s.busy = 1'b1;
      end
      NRCR_OP_CACHE_LAST: begin // [RL10]
        s.c1_en = 1'b1;
        s.c1 = `NRCR_OPC_CACHE_LAST;
        s.busy = 1'b1;
      end
      NRCR_OP_READ_BYTE: s.rd = 1'b1; // [RL4]
      NRCR_OP_STATUS: begin
        s.c1_en = 1'b1;
        s.c1 = `NRCR_OPC_STATUS;
        s.rd = 1'b1;
      end
      NRCR_OP_READ_MODE: begin
        s.c1_en = 1'b1;
        s.c1 = `NRCR_OPC_READ;
      end
      NRCR_OP_RESET: begin
        s.c1_en = 1'b1;
        s.c1 = `NRCR_OPC_RESET;
        s.busy = 1'b1;
      end
      default: s = '0;
    endcase
    return s;
  endfunction

  // Reset release through two flops
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  nrcr_sync #(.W(1), .INIT(1'b1)) u_rb_sync (
    .clk(ref_clk),
    .rst_n(rst_n_q),
    .d(nand_rb_n),
    .q(rb_s)
  );

  nrcr_sync #(.W(8), .INIT(8'h00)) u_dq_sync (
    .clk(ref_clk),
    .rst_n(rst_n_q),
    .d(nand_dq_in),
    .q(dq_s)
  );

  // Legality of a new op against what the die is doing
  always_comb begin
    cmd_op = nrcr_op_type'(reg_wdata[3:0]);
    cmd_wr = reg_wr && (reg_addr == `NRCR_REG_CMD);
    last_page = (page_q == PB'(PAGES_PER_BLOCK - 1));
    cmd_ok = (st_q == S_IDLE) && (reg_wdata[3:0] <= 4'(NRCR_OP_RESET));
    if (!rb_s && !(cmd_op inside {NRCR_OP_STATUS, NRCR_OP_RESET})) begin
      cmd_ok = 1'b0; // [RL13]
    end
    if (cmd_op == NRCR_OP_COL_CHANGE && !loaded_q) begin
      cmd_ok = 1'b0; // [RL2] [RL3]
    end
    if (cmd_op inside {NRCR_OP_CACHE_SEQ, NRCR_OP_CACHE_RAND,
                       NRCR_OP_CACHE_LAST} && !loaded_q) begin
      cmd_ok = 1'b0; // [RL5]
    end
    if (cmd_op == NRCR_OP_CACHE_LAST && !cache_q) begin
      cmd_ok = 1'b0; // [RL17]
    end
    if (cmd_op == NRCR_OP_CACHE_SEQ && last_page) begin
      cmd_ok = 1'b0; // [RL15]
    end
    if (cmd_op == NRCR_OP_CACHE_RAND && row_q[PLANE_BIT] != plane_q) begin
      cmd_ok = 1'b0; // [RL16]
    end
    if (cmd_op == NRCR_OP_PAGE_READ && cache_q) begin
      cmd_ok = 1'b0; // [RL14] [RL17]
    end
    start = cmd_wr && cmd_ok;
    refuse = cmd_wr && !cmd_ok;
    wr_stage = st_q inside {S_CMD1, S_ADDR, S_CMD2};
    lo_cyc = (st_q == S_READ) ? `NRCR_RP_CYC : `NRCR_WP_CYC + 8'h01;
    hi_cyc = (st_q == S_READ) ? `NRCR_REH_CYC : `NRCR_WH_CYC;
    unique case (acnt_q)
      3'h0: abyte = col_q[7:0];
      3'h1: abyte = col_q[15:8];
      3'h2: abyte = row_q[7:0];
      3'h3: abyte = row_q[15:8];
      default: abyte = row_q[23:16];
    endcase
  end

  // Stage sequencer; one strobe per command, address or data cycle
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      st_q <= S_IDLE;
      op_q <= NRCR_OP_PAGE_READ;
      seq_q <= '0;
      ph_q <= 1'b0;
      tcnt_q <= 8'h00;
      acnt_q <= 3'h0;
    end else begin
      unique case (st_q)
        S_IDLE: begin
          if (start) begin
            op_q <= cmd_op;
            seq_q <= decode(cmd_op);
            st_q <= after(S_IDLE, decode(cmd_op));
            ph_q <= 1'b0;
            tcnt_q <= 8'h00;
            acnt_q <= 3'h0;
          end
        end
        S_CMD1, S_ADDR, S_CMD2, S_READ: begin
          if (!ph_q) begin
            if (tcnt_q == lo_cyc - 8'h01) begin
              ph_q <= 1'b1;
              tcnt_q <= 8'h00;
            end else begin
              tcnt_q <= tcnt_q + 8'h01;
            end
          end else if (tcnt_q == hi_cyc - 8'h01) begin
            ph_q <= 1'b0;
            tcnt_q <= 8'h00;
            if (st_q == S_ADDR && acnt_q != seq_q.naddr - 3'h1) begin
              acnt_q <= acnt_q + 3'h1;
            end else begin
              st_q <= after(st_q, seq_q);
            end
          end else begin
            tcnt_q <= tcnt_q + 8'h01;
          end
        end
        S_WB: begin
          // Busy line needs time to fall before it means anything
          if (tcnt_q == `NRCR_WB_CYC - 8'h01) begin
            st_q <= S_RB;
            tcnt_q <= 8'h00;
          end else begin
            tcnt_q <= tcnt_q + 8'h01;
          end
        end
        S_RB: begin
          if (rb_s) begin
            st_q <= after(S_RB, seq_q); // [RL13]
          end
        end
        S_DONE: st_q <= S_IDLE;
      endcase
    end
  end

  // Pins follow the stage one cycle later; WE falls a cycle after
  // CLE, ALE and DQ settle so setup holds
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      nand_ce_n <= 1'b1;
      nand_cle <= 1'b0;
      nand_ale <= 1'b0;
      nand_we_n <= 1'b1;
      nand_re_n <= 1'b1;
      nand_dq_oe <= 1'b0;
      nand_dq_out <= 8'h00;
    end else begin
      nand_ce_n <= (st_q == S_IDLE);
      nand_cle <= st_q inside {S_CMD1, S_CMD2};
      nand_ale <= (st_q == S_ADDR);
      nand_we_n <= !(wr_stage && !ph_q && tcnt_q != 8'h00);
      nand_re_n <= !(st_q == S_READ && !ph_q); // [RL4]
      nand_dq_oe <= wr_stage;
      nand_dq_out <= (st_q == S_CMD1) ? seq_q.c1 :
                     (st_q == S_CMD2) ? seq_q.c2 :
                     (st_q == S_ADDR) ? abyte : 8'h00;
    end
  end

  // Byte capture at the end of the read strobe low time; the low
  // time covers access time plus synchroniser lag
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      data_q <= 8'h00;
    end else if (st_q == S_READ && !ph_q && tcnt_q == lo_cyc - 8'h01) begin
      data_q <= dq_s;
    end
  end

  // Host view of the die: loaded page, cache mode, column pointer
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      loaded_q <= 1'b0;
      cache_q <= 1'b0;
      fetch_q <= 1'b0;
      exp_q <= 2'h3;
      plane_q <= 1'b0;
      page_q <= '0;
      colp_q <= 16'h0000;
    end else if (st_q == S_DONE) begin
      unique case (op_q)
        NRCR_OP_PAGE_READ: begin
          loaded_q <= 1'b1;
          exp_q <= 2'h3; // [RL5]
          page_q <= row_q[PB-1:0];
          plane_q <= row_q[PLANE_BIT];
          colp_q <= col_q;
        end
        NRCR_OP_CACHE_SEQ: begin
          cache_q <= 1'b1; // [RL8] [RL9]
          fetch_q <= 1'b1;
          exp_q <= 2'h2; // [RL11]
          page_q <= page_q + PB'(1); // [RL6]
          colp_q <= 16'h0000; // [RL12]
        end
        NRCR_OP_CACHE_RAND: begin
          cache_q <= 1'b1; // [RL7] [RL9]
          fetch_q <= 1'b1;
          exp_q <= 2'h2; // [RL11]
          page_q <= row_q[PB-1:0];
          colp_q <= 16'h0000; // [RL12]
        end
        NRCR_OP_CACHE_LAST: begin
          cache_q <= 1'b0; // [RL10]
          fetch_q <= 1'b0;
          exp_q <= 2'h3; // [RL11]
          colp_q <= 16'h0000; // [RL12]
        end
        NRCR_OP_COL_CHANGE: colp_q <= col_q; // [RL1]
        NRCR_OP_READ_BYTE: colp_q <= colp_q + 16'h0001; // [RL4]
        NRCR_OP_RESET: begin
          loaded_q <= 1'b0;
          cache_q <= 1'b0;
          fetch_q <= 1'b0;
          exp_q <= 2'h3;
          colp_q <= 16'h0000;
        end
        default: colp_q <= colp_q;
      endcase
    end
  end

  // Software registers; a set in the clearing cycle wins
  always_comb begin
    ev_set = 3'h0;
    ev_set[`NRCR_IRQ_DONE] = (st_q == S_DONE);
    ev_set[`NRCR_IRQ_REFUSED] = refuse;
    ev_set[`NRCR_IRQ_READY] = rb_s && !rb_prev_q;
    ev_clr = (reg_wr && reg_addr == `NRCR_REG_IRQ_STAT) ?
             reg_wdata[2:0] : 3'h0;
  end

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      col_q <= `NRCR_COL_RST;
      row_q <= `NRCR_ROW_RST;
      mask_q <= `NRCR_MASK_RST;
      stat_q <= 3'h0;
      rb_prev_q <= 1'b1;
    end else begin
      rb_prev_q <= rb_s;
      stat_q <= (stat_q & ~ev_clr) | ev_set;
      if (reg_wr && reg_addr == `NRCR_REG_COL) begin
        col_q <= reg_wdata[15:0];
      end
      if (reg_wr && reg_addr == `NRCR_REG_ROW) begin
        row_q <= reg_wdata[23:0];
      end
      if (reg_wr && reg_addr == `NRCR_REG_IRQ_MASK) begin
        mask_q <= reg_wdata[2:0];
      end
    end
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      reg_rdata <= 32'h00000000;
    end else if (!reg_rd) begin
      reg_rdata <= 32'h00000000;
    end else begin
      unique case (reg_addr)
        `NRCR_REG_COL: reg_rdata <= {16'h0000, col_q};
        `NRCR_REG_ROW: reg_rdata <= {8'h00, row_q};
        `NRCR_REG_DATA: reg_rdata <= {24'h000000, data_q};
        `NRCR_REG_STATE: reg_rdata <= {colp_q, 8'h00, last_page,
                                      exp_q, fetch_q, cache_q,
                                      loaded_q, rb_s, st_q != S_IDLE};
        `NRCR_REG_IRQ_STAT: reg_rdata <= {29'h00000000, stat_q};
        `NRCR_REG_IRQ_MASK: reg_rdata <= {29'h00000000, mask_q};
        default: reg_rdata <= 32'h00000000;
      endcase
    end
  end

  assign irq = |(stat_q & mask_q);
endmodule

// File: verification/nrcr_die.sv
// Behavioural die model: page, data and cache registers, status bits.
// Assumes host pins arrive directly; busy times are given in ns.
`timescale 1ns/1ps
module nrcr_die #(
  parameter int ARRAY_NS = 2000,
  parameter int FIRST_NS = 600,
  parameter int NEXT_NS = 1000
) (
  input wire logic ce_n,
  input wire logic cle,
  input wire logic ale,
  input wire logic we_n,
  input wire logic re_n,
  input wire logic [7:0] dq_in,
  output logic [7:0] dq_out,
  output logic rb_n,
  output int viol,
  output int ncmd
);
  logic [7:0] ab [5];
  logic [7:0] lastc;
  logic [23:0] cpg, dpg, nxt;
  logic [15:0] col;
  logic loaded, fetch, stat_md;
  logic [1:0] st;
  int na, bt;
  initial begin
    rb_n = 1'b1;
    dq_out = 8'h5A;
    {loaded, fetch, stat_md, na, viol, ncmd} = '0;
    {st, col, cpg, dpg, lastc} = '0;
  end
  // Busy phase then new status; output column restarts
  task automatic busy(input int ns, input logic [1:0] s, input logic [15:0] c);
    st = 2'b00;
    #60 rb_n = 1'b0;
    #(ns) rb_n = 1'b1;
    st = s;
    col = c;
  endtask
  // Command and address latch on the rising write strobe
  always @(posedge we_n) if (ce_n === 1'b0) begin
    if (ale && na < 5) begin
      ab[na] = dq_in;
      na++;
    end else if (cle) begin
      ncmd++;
      if (!rb_n && !(dq_in inside {8'h70, 8'h78, 8'hFF})) viol++;
      if (fetch && !(dq_in inside {8'h70, 8'h78, 8'h00, 8'h31, 8'h05,
          8'hE0, 8'hFF, 8'h3F})) viol++;
      stat_md = 1'b0;
      case (dq_in)
        8'h00, 8'h05: na = 0;
        8'h30: begin
          loaded = 1'b1;
          fetch = 1'b0;
          cpg = {ab[4], ab[3], ab[2]};
          dpg = cpg;
          fork busy(ARRAY_NS, 2'b11, {ab[1], ab[0]}); join_none
        end
        8'h31: begin
          if (lastc == 8'h00 && na == 5) begin
            nxt = {ab[4], ab[3], ab[2]};
            if (nxt[7] != dpg[7]) viol++;
          end else begin
            if (dpg[6:0] == 7'h7F) viol++;
            nxt = dpg + 24'h1;
          end
          cpg = dpg;
          dpg = nxt;
          // Busy time fixed here; the forked task reads it only later
          bt = fetch ? NEXT_NS : FIRST_NS;
          fork busy(bt, 2'b10, 16'h0); join_none
          fetch = 1'b1;
        end
        8'h3F: begin
          cpg = dpg;
          fetch = 1'b0;
          fork busy(NEXT_NS, 2'b11, 16'h0); join_none
        end
        8'hE0: if (loaded) col = {ab[1], ab[0]};
        8'h70: stat_md = 1'b1;
        8'hFF: begin
          {loaded, fetch} = 2'b00;
          fork busy(1000, 2'b11, 16'h0); join_none
        end
        default: ;
      endcase
      lastc = dq_in;
    end
  end
  // Byte or status out while the read strobe is low
  always @(negedge re_n) if (ce_n === 1'b0) begin
    dq_out = stat_md ? {1'b0, st, 5'h00} : (cpg[7:0] ^ col[7:0]);
  end
  // Released bus flips so a stale byte never looks valid
  always @(posedge re_n) begin
    if (!stat_md) col++;
    dq_out = ~dq_out;
  end
endmodule

// File: verification/nrcr_host_sva.sv
// Checker for the host's register port and die pins.
// Assumes it is bound to every host instance.
`timescale 1ns/1ps
module nrcr_host_sva (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic nand_ce_n,
  input wire logic nand_cle,
  input wire logic nand_ale,
  input wire logic nand_we_n,
  input wire logic nand_re_n,
  input wire logic [7:0] nand_dq_out,
  input wire logic nand_dq_oe,
  input wire logic nand_rb_n
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data seen without a read");
  AST_LATCH_EXCL: assert property (!(nand_cle && nand_ale))
    else $error("command and address latch both high");
  AST_STROBE_EXCL: assert property (nand_we_n || nand_re_n)
    else $error("write and read strobe both low");
  AST_CE_HELD: assert property (!(nand_we_n && nand_re_n) |-> !nand_ce_n)
    else $error("strobe without chip enable");
  AST_WE_DRIVES: assert property (!nand_we_n |-> nand_dq_oe &&
    (nand_cle || nand_ale)) else $error("write strobe without drive");
  AST_RE_RELEASE: assert property (!nand_re_n |-> !nand_dq_oe)
    else $error("host drives bus during read");
  AST_RE_WIDTH: assert property ($fell(nand_re_n) |->
    !nand_re_n [*6] ##1 nand_re_n) else $error("read strobe width");
  AST_WE_WIDTH: assert property ($fell(nand_we_n) |-> !nand_we_n [*2])
    else $error("write strobe too short");
  AST_WE_HOLD: assert property ($fell(nand_we_n) |-> ##1
    $stable(nand_dq_out) && $stable(nand_cle)) else $error("byte moved");
  AST_BUSY_QUIET: assert property ((!nand_rb_n [*6] ##0
    $fell(nand_we_n)) |-> nand_cle && nand_dq_out inside {8'h70, 8'hFF})
    else $error("command other than status or reset while busy");
endmodule
bind nrcr_host nrcr_host_sva nrcr_host_sva_i (.ref_clk(ref_clk),
  .nrst(nrst), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .nand_ce_n(nand_ce_n), .nand_cle(nand_cle), .nand_ale(nand_ale),
  .nand_we_n(nand_we_n), .nand_re_n(nand_re_n),
  .nand_dq_out(nand_dq_out), .nand_dq_oe(nand_dq_oe),
  .nand_rb_n(nand_rb_n));

// File: verification/testbench.sv
// Self-checking bench: register-port calls run cached reads on the host
// against the die model; expected bytes are page xor column.
`timescale 1ns/1ps
`include "nrcr_cfg.svh"
module testbench;
  import nrcr_pkg::*;
  logic ref_clk, nrst, reg_wr, reg_rd, irq, ce_n, cle, ale, we_n, re_n;
  logic oe, rb_n;
  logic [7:0] reg_addr, dq_o, dq_d, dq;
  logic [31:0] reg_wdata, reg_rdata, v;
  int fails, samples_checked, viol, ncmd, n0;
  // Bus level: host wins while it drives, else the die
  assign dq = oe ? dq_o : dq_d;
  nrcr_host nrcr_host_i (.ref_clk(ref_clk), .nrst(nrst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .nand_ce_n(ce_n),
    .nand_cle(cle), .nand_ale(ale), .nand_we_n(we_n), .nand_re_n(re_n),
    .nand_dq_out(dq_o), .nand_dq_oe(oe), .nand_dq_in(dq),
    .nand_rb_n(rb_n));
  nrcr_die nrcr_die_i (.ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
    .re_n(re_n), .dq_in(dq), .dq_out(dq_d), .rb_n(rb_n), .viol(viol),
    .ncmd(ncmd));
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Strobe dropped with an idle edge after, so calls never collide
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge ref_clk);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    rd(a, v);
    check(v, e);
  endtask
  // Start an op, wait bounded for done or refused, clear, compare
  task automatic run(input nrcr_op_type o, input logic [1:0] e);
    wr(`NRCR_REG_CMD, 32'(o));
    for (int i = 0; i < 3000; i++) begin
      rd(`NRCR_REG_IRQ_STAT, v);
      if (v[1:0] != 2'b00) break;
    end
    if (v[1:0] == 2'b00) begin
      fails++;
      tally_and_finish;
    end
    wr(`NRCR_REG_IRQ_STAT, v);
    check(32'(v[1:0]), 32'(e));
  endtask
  task automatic rdbyte(input logic [7:0] e);
    run(NRCR_OP_READ_BYTE, 2'b01);
    rd_chk(`NRCR_REG_DATA, {24'h0, e});
  endtask
  // Host's view and the die's own status byte
  task automatic die_st(input logic [1:0] e);
    rd(`NRCR_REG_STATE, v);
    check(32'(v[6:5]), 32'(e));
    run(NRCR_OP_STATUS, 2'b01);
    rd(`NRCR_REG_DATA, v);
    check(32'(v[6:5]), 32'(e));
    run(NRCR_OP_READ_MODE, 2'b01);
  endtask
  initial begin
    {nrst, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    {fails, samples_checked} = '0;
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (8) @(posedge ref_clk);
    rd_chk(`NRCR_REG_COL, 32'h0);
    rd_chk(`NRCR_REG_ROW, 32'h0);
    rd_chk(`NRCR_REG_IRQ_MASK, 32'h0);
    wr(8'h1C, 32'hFFFFFFFF);
    rd_chk(8'h1C, 32'h0);
    n0 = ncmd;
    run(NRCR_OP_COL_CHANGE, 2'b10);
    check(ncmd, n0);
    $display("test reset_and_refusal done");
    wr(`NRCR_REG_ROW, 32'h5);
    wr(`NRCR_REG_COL, 32'h3);
    run(NRCR_OP_PAGE_READ, 2'b01);
    die_st(2'b11);
    rdbyte(8'h06);
    rdbyte(8'h01);
    for (int k = 0; k < 2; k++) begin
      wr(`NRCR_REG_COL, 32'(k ? 16'h2 : 16'h10));
      run(NRCR_OP_COL_CHANGE, 2'b01);
      rdbyte(k ? 8'h07 : 8'h15);
    end
    $display("test page_and_column done");
    run(NRCR_OP_CACHE_SEQ, 2'b01);
    die_st(2'b10);
    rdbyte(8'h05);
    run(NRCR_OP_CACHE_SEQ, 2'b01);
    rdbyte(8'h06);
    wr(`NRCR_REG_ROW, 32'h9);
    wr(`NRCR_REG_COL, 32'h7);
    run(NRCR_OP_CACHE_RAND, 2'b01);
    rdbyte(8'h07);
    wr(`NRCR_REG_ROW, 32'h89);
    run(NRCR_OP_CACHE_RAND, 2'b10);
    run(NRCR_OP_PAGE_READ, 2'b10);
    run(NRCR_OP_CACHE_LAST, 2'b01);
    die_st(2'b11);
    rdbyte(8'h09);
    run(NRCR_OP_CACHE_LAST, 2'b10);
    $display("test cache_sequence done");
    wr(`NRCR_REG_ROW, 32'h7E);
    wr(`NRCR_REG_COL, 32'h0);
    run(NRCR_OP_PAGE_READ, 2'b01);
    run(NRCR_OP_CACHE_SEQ, 2'b01);
    rd(`NRCR_REG_STATE, v);
    check(32'(v[7]), 32'h1);
    run(NRCR_OP_CACHE_SEQ, 2'b10);
    run(NRCR_OP_CACHE_LAST, 2'b01);
    rdbyte(8'h7F);
    $display("test block_end done");
    run(NRCR_OP_RESET, 2'b01);
    rd(`NRCR_REG_STATE, v);
    check(32'(v[6:0]), 32'h62);
    run(NRCR_OP_COL_CHANGE, 2'b10);
    $display("test die_reset done");
    wr(`NRCR_REG_IRQ_MASK, 32'h1);
    wr(`NRCR_REG_CMD, 32'(NRCR_OP_READ_BYTE));
    for (int i = 0; i < 200 && !irq; i++) @(posedge ref_clk);
    check(irq, 1'b1);
    wr(`NRCR_REG_IRQ_STAT, 32'h7);
    check(irq, 1'b0);
    wr(`NRCR_REG_CMD, 32'hF);
    check(irq, 1'b0);
    rd(`NRCR_REG_IRQ_STAT, v);
    check(32'(v[1]), 32'h1);
    wr(`NRCR_REG_IRQ_MASK, 32'h2);
    check(irq, 1'b1);
    wr(`NRCR_REG_IRQ_STAT, 32'h7);
    check(irq, 1'b0);
    check(viol, 0);
    $display("test interrupts done");
    tally_and_finish;
  end
endmodule
